// ### core/cmd_dispatch_pkg.sv
/*
  package for the command dispatch and test register block: register
  offsets, field positions, reset values, command codes and the state enum.
  assumes an 8-bit register port with 6-bit addresses.
*/
package cmd_dispatch_pkg;

  // widths
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [5:0] OFS_COMMAND = 6'h01;
  localparam logic [5:0] OFS_FIFO_DATA = 6'h09;
  localparam logic [5:0] OFS_FIFO_LEVEL = 6'h0a;
  localparam logic [5:0] OFS_BIT_FRAMING = 6'h0d;
  localparam logic [5:0] OFS_ANALOG_TEST = 6'h38;
  localparam logic [5:0] OFS_FIRST_DAC = 6'h39;
  localparam logic [5:0] OFS_SECOND_DAC = 6'h3a;
  localparam logic [5:0] OFS_ADC_SAMPLE = 6'h3b;
  localparam logic [5:0] OFS_PROD_A = 6'h3c;
  localparam logic [5:0] OFS_PROD_B = 6'h3d;
  localparam logic [5:0] OFS_PROD_C = 6'h3e;
  localparam logic [5:0] OFS_PROD_D = 6'h3f;

  // reset values
  localparam logic [7:0] RST_PROD_A = 8'hff;
  localparam logic [7:0] RST_PROD_B = 8'h00;
  localparam logic [7:0] RST_PROD_C = 8'h03;
  localparam logic [7:0] RST_PROD_D = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // field layout
  localparam int CMD_CODE_MSB = 3;
  localparam int CMD_UPPER_LSB = 4;
  localparam int DAC_MSB = 5;
  localparam int SEL1_LSB = 4;
  localparam int SEND_TRIGGER_BIT = 7;
  localparam logic [5:0] DAC_MASK = 6'h3f;
  localparam logic [7:0] CMD_UPPER_MASK = 8'hf0;

  // analog select value routing a test dac to its aux pin
  localparam logic [3:0] SEL_TEST_DAC = 4'h1;

  // fifo depth and argument count of the argument-taking operation
  localparam int FIFO_DEPTH = 64;
  localparam int FIFO_AW = 6;
  localparam logic [3:0] AUTH_ARG_COUNT = 4'hc;

  // command codes
  typedef enum logic [3:0] {
    CMD_IDLE = 4'b0000,
    CMD_MEM = 4'b0001,
    CMD_RANDOM_ID = 4'b0010,
    CMD_CALC_CRC = 4'b0011,
    CMD_TRANSMIT = 4'b0100,
    CMD_KEEP = 4'b0111,
    CMD_RECEIVE = 4'b1000,
    CMD_TRANSCEIVE = 4'b1100,
    CMD_AUTHENT = 4'b1110,
    CMD_SOFT_RESET = 4'b1111
  } cmd_code_t;

  // operation sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_STREAM = 3'b001,
    ST_WAIT_SEND = 3'b010,
    ST_SENDING = 3'b011,
    ST_RECEIVING = 3'b100,
    ST_COLLECT_ARGS = 3'b101,
    ST_PROCESS = 3'b110
  } op_state_t;

  // register port request
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // analog aux pin drive
  typedef struct packed {
    logic [5:0] level;
    logic enable;
  } aux_drive_t;

endpackage : cmd_dispatch_pkg

// ### core/command_dispatch.sv
/*
  command dispatch and test register block: command register, a 64-byte
  fifo that carries arguments and data, the operation sequencer, the test
  dac registers with aux routing, adc readback and production-test registers.
  assumes a single-cycle register port on the same clock; the rf datapath
  sits outside and reports via txDone/rxDone and takes bytes via streamByte/streamValid.
*/
// Implementation choice: the strobed register port.
// Notes on behaviour
// - writing a command code starts that operation
// - arguments and data pass only through fifo
// - stream operations consume fifo data immediately
// - transceive transmits only after send trigger
// - argument operation waits for full argument count
// - starting an operation never clears fifo
// - new command code abandons the running operation
// - first dac register holds six-bit value
// - select 0001b routes first dac to aux 1
// - second dac register holds six-bit value
// - select 0001b routes second dac to aux 2
// - production registers reset ff, 00, 03, 00
// - idle code cancels operation, device idles
// - keep code changes bits, not operation
`timescale 1ns/10ps
module command_dispatch (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // rf datapath side
  input wire logic [3:0] adcInPhase,
  input wire logic [3:0] adcQuadrature,
  input wire logic txDone,
  input wire logic rxDone,
  output logic [7:0] streamByte,
  output logic streamValid,
  output logic txActive,
  output logic rxActive,
  output logic [3:0] activeOp,
  // analog aux pins
  output logic [5:0] auxPin1Level,
  output logic auxPin1Enable,
  output logic [5:0] auxPin2Level,
  output logic auxPin2Enable
);

  // combinational request bundle view
  cmd_dispatch_pkg::reg_req_t req;
  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // register storage
  logic [7:0] cmdUpper_ff; // upper command register bits, written by keep code too
  logic [3:0] opCode_ff; // operation now running
  logic [7:0] analogSel_ff; // aux select fields
  logic [5:0] firstDac_ff;
  logic [5:0] secondDac_ff;
  logic [7:0] prodA_ff;
  logic [7:0] prodB_ff;
  logic [7:0] prodC_ff;
  logic [7:0] prodD_ff;
  logic sendTrigger_ff; // self-clearing once transmission starts
  cmd_dispatch_pkg::op_state_t state_ff;
  cmd_dispatch_pkg::op_state_t nxt_state;
  logic [3:0] argCount_ff; // arguments taken by argument operation

  // fifo storage
  logic [7:0] fifoMem [cmd_dispatch_pkg::FIFO_DEPTH];
  logic [5:0] wrPtr_ff;
  logic [5:0] rdPtr_ff;
  logic [6:0] level_ff;
  logic [7:0] streamByte_ff;
  logic streamValid_ff;

  // decode helpers
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // write strobes
  logic cmdWrite;
  logic newOpCode;
  logic fifoPush;
  logic fifoPop;
  logic fifoEmpty;
  logic fifoFull;
  logic consume;
  assign cmdWrite = req.wr && hit(req.addr, cmd_dispatch_pkg::OFS_COMMAND);
  // keep code touches only the upper bits
  assign newOpCode = cmdWrite &&
    (req.wdata[cmd_dispatch_pkg::CMD_CODE_MSB:0] != cmd_dispatch_pkg::CMD_KEEP);
  assign fifoEmpty = (level_ff == 7'h00);
  assign fifoFull = (level_ff == 7'(cmd_dispatch_pkg::FIFO_DEPTH));
  assign fifoPush = req.wr && hit(req.addr, cmd_dispatch_pkg::OFS_FIFO_DATA) && !fifoFull;

  // consumption: streams drain right away, transceive only while sending
  always_comb
  begin
    consume = 1'b0;
    case (state_ff)
      cmd_dispatch_pkg::ST_STREAM: consume = !fifoEmpty;
      cmd_dispatch_pkg::ST_SENDING: consume = !fifoEmpty;
      cmd_dispatch_pkg::ST_COLLECT_ARGS: consume = !fifoEmpty;
      default: consume = 1'b0;
    endcase
  end
  // host pops read the fifo too; the operation's consumer wins
  assign fifoPop = consume ||
    (req.rd && hit(req.addr, cmd_dispatch_pkg::OFS_FIFO_DATA) && !fifoEmpty && !consume);

  // fifo write side; never cleared by a command start
  always_ff @(posedge clock)
  begin
    if (fifoPush)
    begin
      fifoMem[wrPtr_ff] <= req.wdata;
    end
  end

  // fifo pointers and level
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_ff <= 6'h00;
      rdPtr_ff <= 6'h00;
      level_ff <= 7'h00;
    end
    else
    begin
      if (fifoPush)
        wrPtr_ff <= wrPtr_ff + 6'h01;
      if (fifoPop)
        rdPtr_ff <= rdPtr_ff + 6'h01;
      // push and pop together leave level unchanged
      level_ff <= level_ff + {6'h00, fifoPush} - {6'h00, fifoPop};
    end
  end

  // byte handed to the rf datapath
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      streamByte_ff <= 8'h00;
      streamValid_ff <= 1'b0;
    end
    else
    begin
      streamValid_ff <= consume;
      if (consume)
        streamByte_ff <= fifoMem[rdPtr_ff];
    end
  end

  // operation sequencer next state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      cmd_dispatch_pkg::ST_STREAM: nxt_state = state_ff;
      cmd_dispatch_pkg::ST_WAIT_SEND:
        if (sendTrigger_ff)
          nxt_state = cmd_dispatch_pkg::ST_SENDING;
      cmd_dispatch_pkg::ST_SENDING:
        if (txDone)
          nxt_state = cmd_dispatch_pkg::ST_RECEIVING;
      // transceive repeats: next trigger sends again
      cmd_dispatch_pkg::ST_RECEIVING:
        if (rxDone && opCode_ff == cmd_dispatch_pkg::CMD_TRANSCEIVE)
          nxt_state = cmd_dispatch_pkg::ST_WAIT_SEND;
        else if (rxDone)
          nxt_state = cmd_dispatch_pkg::ST_IDLE;
      // no processing until the last argument byte arrived
      cmd_dispatch_pkg::ST_COLLECT_ARGS:
        if (consume && argCount_ff == cmd_dispatch_pkg::AUTH_ARG_COUNT - 4'h1)
          nxt_state = cmd_dispatch_pkg::ST_PROCESS;
      cmd_dispatch_pkg::ST_PROCESS: nxt_state = state_ff;
      default: nxt_state = cmd_dispatch_pkg::ST_IDLE;
    endcase
    // a fresh code overrides everything above
    if (newOpCode)
    begin
      case (req.wdata[cmd_dispatch_pkg::CMD_CODE_MSB:0])
        cmd_dispatch_pkg::CMD_IDLE: nxt_state = cmd_dispatch_pkg::ST_IDLE;
        cmd_dispatch_pkg::CMD_SOFT_RESET: nxt_state = cmd_dispatch_pkg::ST_IDLE;
        cmd_dispatch_pkg::CMD_TRANSCEIVE: nxt_state = cmd_dispatch_pkg::ST_WAIT_SEND;
        cmd_dispatch_pkg::CMD_RECEIVE: nxt_state = cmd_dispatch_pkg::ST_RECEIVING;
        cmd_dispatch_pkg::CMD_AUTHENT: nxt_state = cmd_dispatch_pkg::ST_COLLECT_ARGS;
        default: nxt_state = cmd_dispatch_pkg::ST_STREAM;
      endcase
    end
  end

  // sequencer state; abandoned on every new code
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= cmd_dispatch_pkg::ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // running operation code
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      opCode_ff <= cmd_dispatch_pkg::CMD_IDLE;
    else if (newOpCode)
      opCode_ff <= req.wdata[cmd_dispatch_pkg::CMD_CODE_MSB:0];
    else if (nxt_state == cmd_dispatch_pkg::ST_IDLE)
      opCode_ff <= cmd_dispatch_pkg::CMD_IDLE;
  end

  // upper command bits, written by any command write
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cmdUpper_ff <= cmd_dispatch_pkg::RST_ZERO;
    else if (cmdWrite)
      cmdUpper_ff <= req.wdata & cmd_dispatch_pkg::CMD_UPPER_MASK;
  end

  // argument counter restarts with each argument operation
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      argCount_ff <= 4'h0;
    else if (newOpCode)
      argCount_ff <= 4'h0;
    else if (consume && state_ff == cmd_dispatch_pkg::ST_COLLECT_ARGS)
      argCount_ff <= argCount_ff + 4'h1;
  end

  // send trigger: host sets it, cleared when sending starts; set wins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sendTrigger_ff <= 1'b0;
    else if (req.wr && hit(req.addr, cmd_dispatch_pkg::OFS_BIT_FRAMING)
             && req.wdata[cmd_dispatch_pkg::SEND_TRIGGER_BIT])
      sendTrigger_ff <= 1'b1;
    else if (state_ff == cmd_dispatch_pkg::ST_WAIT_SEND || newOpCode)
      sendTrigger_ff <= 1'b0;
  end

  // test and analog registers; reserved bits dropped on write
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      analogSel_ff <= cmd_dispatch_pkg::RST_ZERO;
      firstDac_ff <= 6'h00;
      secondDac_ff <= 6'h00;
    end
    else if (req.wr)
    begin
      if (hit(req.addr, cmd_dispatch_pkg::OFS_ANALOG_TEST))
        analogSel_ff <= req.wdata;
      if (hit(req.addr, cmd_dispatch_pkg::OFS_FIRST_DAC))
        firstDac_ff <= req.wdata[cmd_dispatch_pkg::DAC_MSB:0];
      if (hit(req.addr, cmd_dispatch_pkg::OFS_SECOND_DAC))
        secondDac_ff <= req.wdata[cmd_dispatch_pkg::DAC_MSB:0];
    end
  end

  // production-test registers: no user function, writes ignored
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prodA_ff <= cmd_dispatch_pkg::RST_PROD_A;
      prodB_ff <= cmd_dispatch_pkg::RST_PROD_B;
      prodC_ff <= cmd_dispatch_pkg::RST_PROD_C;
      prodD_ff <= cmd_dispatch_pkg::RST_PROD_D;
    end
    else
    begin
      prodA_ff <= prodA_ff;
      prodB_ff <= prodB_ff;
      prodC_ff <= prodC_ff;
      prodD_ff <= prodD_ff;
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      regRdata <= 8'h00;
    else if (req.rd)
    begin
      case (req.addr)
        cmd_dispatch_pkg::OFS_COMMAND: regRdata <= cmdUpper_ff | {4'h0, opCode_ff};
        cmd_dispatch_pkg::OFS_FIFO_DATA: regRdata <= fifoEmpty ? 8'h00 : fifoMem[rdPtr_ff];
        cmd_dispatch_pkg::OFS_FIFO_LEVEL: regRdata <= {1'b0, level_ff};
        cmd_dispatch_pkg::OFS_BIT_FRAMING: regRdata <= {sendTrigger_ff, 7'h00};
        cmd_dispatch_pkg::OFS_ANALOG_TEST: regRdata <= analogSel_ff;
        cmd_dispatch_pkg::OFS_FIRST_DAC: regRdata <= {2'b00, firstDac_ff};
        cmd_dispatch_pkg::OFS_SECOND_DAC: regRdata <= {2'b00, secondDac_ff};
        cmd_dispatch_pkg::OFS_ADC_SAMPLE: regRdata <= {adcInPhase, adcQuadrature};
        cmd_dispatch_pkg::OFS_PROD_A: regRdata <= prodA_ff;
        cmd_dispatch_pkg::OFS_PROD_B: regRdata <= prodB_ff;
        cmd_dispatch_pkg::OFS_PROD_C: regRdata <= prodC_ff;
        cmd_dispatch_pkg::OFS_PROD_D: regRdata <= prodD_ff;
        default: regRdata <= 8'h00; // unmapped reads zero
      endcase
    end
  end

  // aux routing; other select values leave the pin undriven here
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      auxPin1Level <= 6'h00;
      auxPin1Enable <= 1'b0;
      auxPin2Level <= 6'h00;
      auxPin2Enable <= 1'b0;
    end
    else
    begin
      auxPin1Enable <= (analogSel_ff[7:cmd_dispatch_pkg::SEL1_LSB] == cmd_dispatch_pkg::SEL_TEST_DAC);
      auxPin1Level <= (analogSel_ff[7:cmd_dispatch_pkg::SEL1_LSB] == cmd_dispatch_pkg::SEL_TEST_DAC)
        ? firstDac_ff : 6'h00;
      auxPin2Enable <= (analogSel_ff[3:0] == cmd_dispatch_pkg::SEL_TEST_DAC);
      auxPin2Level <= (analogSel_ff[3:0] == cmd_dispatch_pkg::SEL_TEST_DAC) ? secondDac_ff : 6'h00;
    end
  end

  // status toward the rf datapath
  assign streamByte = streamByte_ff;
  assign streamValid = streamValid_ff;
  assign txActive = (state_ff == cmd_dispatch_pkg::ST_SENDING);
  assign rxActive = (state_ff == cmd_dispatch_pkg::ST_RECEIVING);
  assign activeOp = opCode_ff;

endmodule : command_dispatch

// ### tb/cmd_dispatch_monitor.sv
/* port checker for command_dispatch.
   assumes one clock and the async active-low reset. */
`timescale 1ns/10ps
module cmd_dispatch_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  // rf side
  input wire logic [3:0] adcInPhase,
  input wire logic [3:0] adcQuadrature,
  input wire logic txDone,
  input wire logic rxDone,
  input wire logic [7:0] streamByte,
  input wire logic streamValid,
  input wire logic txActive,
  input wire logic rxActive,
  input wire logic [3:0] activeOp,
  // aux pins
  input wire logic [5:0] auxPin1Level,
  input wire logic auxPin1Enable,
  input wire logic [5:0] auxPin2Level,
  input wire logic auxPin2Enable
);
  // short names for the offsets watched here
  localparam logic [5:0] A_CMD = cmd_dispatch_pkg::OFS_COMMAND;
  localparam logic [5:0] A_FRM = cmd_dispatch_pkg::OFS_BIT_FRAMING;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // command write that starts an operation
  sequence s_start;
    regWr && regAddr == A_CMD && regWdata[3:0] != 4'h7 && regWdata[3:0] != 4'hf;
  endsequence
  // keep code, no rf event beside it
  sequence s_keep;
    regWr && regAddr == A_CMD && regWdata[3:0] == 4'h7 && !txDone && !rxDone;
  endsequence
  // send trigger while transceive waits
  sequence s_trig;
    regWr && regAddr == A_FRM && regWdata[7] && activeOp == 4'hc && !txActive && !rxActive;
  endsequence
  // end of transmission, no command write racing it
  sequence s_tx_end;
    txActive && txDone && !(regWr && regAddr == A_CMD);
  endsequence
  a_cmd_starts_op: assert property (s_start |=> activeOp == $past(regWdata[3:0]))
    else $error("command write did not start its operation");
  a_keep_holds_op: assert property (s_keep |=> $stable(activeOp))
    else $error("keep code changed the running operation");
  a_idle_is_quiet: assert property ((activeOp == 4'h0) [*2] |-> !streamValid && !txActive && !rxActive)
    else $error("idle block is still active");
  // the trigger is registered first, so sending starts two edges after its write
  a_send_on_trigger: assert property ($rose(txActive) |->
    $past(regWr && regAddr == A_FRM && regWdata[7], 2))
    else $error("transmission began without a send trigger");
  a_trigger_sends: assert property (s_trig |=> ##1 txActive)
    else $error("send trigger did not start transmission");
  a_rx_after_tx: assert property (s_tx_end |=> rxActive && !txActive)
    else $error("receive did not follow transmission");
  a_rx_end_idle: assert property (activeOp == 4'h8 && rxDone && !regWr |=> activeOp == 4'h0)
    else $error("receive did not end on rx done");
  a_aux_routing: assert property (regWr && regAddr == cmd_dispatch_pkg::OFS_ANALOG_TEST |-> ##2
    auxPin1Enable == ($past(regWdata[7:4], 2) == 4'h1) && auxPin2Enable == ($past(regWdata[3:0], 2) == 4'h1))
    else $error("aux enable does not follow the select fields");
  a_dac1_level: assert property (regWr && regAddr == cmd_dispatch_pkg::OFS_FIRST_DAC |-> ##2
    // level shows the dac only while routed, zero otherwise
    auxPin1Level == (auxPin1Enable ? $past(regWdata[5:0], 2) : 6'h00))
    else $error("aux 1 level does not follow the first dac");
  a_adc_readback: assert property (regRd && regAddr == cmd_dispatch_pkg::OFS_ADC_SAMPLE |=>
    regRdata == {$past(adcInPhase), $past(adcQuadrature)})
    else $error("adc readback wrong");
  a_prod_c_fixed: assert property (regRd && regAddr == cmd_dispatch_pkg::OFS_PROD_C |=>
    regRdata == cmd_dispatch_pkg::RST_PROD_C)
    else $error("production register c changed");
endmodule : cmd_dispatch_monitor

// ### tb/rf_side_model.sv
/* rf datapath stand-in: ends each tx or rx phase after a set length.
   assumes level txActive/rxActive from the block on the same clock. */
`timescale 1ns/10ps
module rf_side_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // pace: prompt or slow phases
  input wire logic slow,
  // block side
  input wire logic txActive,
  input wire logic rxActive,
  output logic txDone,
  output logic rxDone,
  output logic [3:0] adcInPhase,
  output logic [3:0] adcQuadrature
);
  logic [5:0] phase_ff; // cycles into the current phase
  logic [7:0] adc_ff; // sample pattern
  logic [5:0] phaseLen; // phase length for this pace
  assign phaseLen = slow ? 6'h14 : 6'h06;
  assign {adcInPhase, adcQuadrature} = adc_ff;
  // count a phase, pulse its end once, restart after the pulse
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      phase_ff <= 6'h00;
      {txDone, rxDone} <= 2'b00;
    end
    else
    begin
      txDone <= txActive && !txDone && phase_ff == phaseLen;
      rxDone <= rxActive && !rxDone && phase_ff == phaseLen;
      phase_ff <= (txActive || rxActive) && !txDone && !rxDone ? phase_ff + 6'h01 : 6'h00;
    end
  // samples move every cycle so a stale readback shows
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      adc_ff <= 8'h00;
    else
      adc_ff <= adc_ff + 8'h35;
endmodule : rf_side_model

// ### tb/tb_top.sv
/* bench for command_dispatch: register tasks and a byte model of the fifo.
   assumes rf_side_model and the port monitor bound below. */
`timescale 1ns/10ps
module tb_top;
  // design and partner signals
  logic clock, rst_n, regWr, regRd, txDone, rxDone, slow;
  logic streamValid, txActive, rxActive, auxPin1Enable, auxPin2Enable;
  logic [3:0] adcInPhase, adcQuadrature, activeOp;
  logic [5:0] regAddr, auxPin1Level, auxPin2Level;
  logic [7:0] regWdata, regRdata, streamByte, rdVal, adcExp, d1, d2, exp1, exp2;
  logic [7:0] fifoQ[$]; // bytes pushed, not yet consumed
  logic [7:0] gotQ[$]; // bytes the block consumed
  logic [7:0] selTab[4] = '{8'h11, 8'h10, 8'h01, 8'h2f};
  logic [7:0] prodTab[4] = '{8'hff, 8'h00, 8'h03, 8'h00};
  localparam logic [5:0] A_CMD = cmd_dispatch_pkg::OFS_COMMAND;
  localparam logic [5:0] A_FRM = cmd_dispatch_pkg::OFS_BIT_FRAMING;
  int mismatches = 0;
  int n_tests = 0;
  int i, k;
  command_dispatch dut_u (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .adcInPhase(adcInPhase),
    .adcQuadrature(adcQuadrature), .txDone(txDone), .rxDone(rxDone), .streamByte(streamByte),
    .streamValid(streamValid), .txActive(txActive), .rxActive(rxActive), .activeOp(activeOp),
    .auxPin1Level(auxPin1Level), .auxPin1Enable(auxPin1Enable), .auxPin2Level(auxPin2Level),
    .auxPin2Enable(auxPin2Enable));
  rf_side_model rf_u (.clock(clock), .rst_n(rst_n), .slow(slow), .txActive(txActive),
    .rxActive(rxActive), .txDone(txDone), .rxDone(rxDone), .adcInPhase(adcInPhase),
    .adcQuadrature(adcQuadrature));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // collect consumed bytes
  always @(posedge clock)
    if (streamValid === 1'b1)
      gotQ.push_back(streamByte);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write, ends just after the sampling edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'b0;
    #1;
  endtask : wr
  // one-cycle read; adc captured where the block samples it
  task automatic rd(input logic [5:0] a);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    adcExp = {adcInPhase, adcQuadrature};
    #1 rdVal = regRdata;
  endtask : rd
  task automatic push(input int n);
    logic [7:0] d;
    repeat (n)
    begin
      d = 8'($urandom);
      fifoQ.push_back(d);
      wr(cmd_dispatch_pkg::OFS_FIFO_DATA, d);
    end
  endtask : push
  // consumed bytes must be the oldest pushed, in order
  task automatic drained(input int n);
    repeat (n + 4) @(posedge clock);
    chk(8'(gotQ.size()), 8'(n));
    while (gotQ.size() > 0 && fifoQ.size() > 0)
      chk(gotQ.pop_front(), fifoQ.pop_front());
    gotQ.delete();
  endtask : drained
  task automatic waitRx(input logic lvl);
    for (int j = 0; j < 100 && rxActive !== lvl; j++)
      @(posedge clock);
    if (rxActive !== lvl)
    begin
      mismatches++;
      $display("[FAIL] %0t receive phase stuck", $time);
      test_done();
    end
  endtask : waitRx
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    void'($urandom(32'h8e79));
    {rst_n, regWr, regRd, slow} = 4'h0;
    regAddr = 6'h00;
    regWdata = 8'h00;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    // production registers keep their value through writes
    for (i = 0; i < 4; i++)
    begin
      rd(6'(cmd_dispatch_pkg::OFS_PROD_A + i));
      chk(rdVal, prodTab[i]);
      wr(6'(cmd_dispatch_pkg::OFS_PROD_A + i), ~prodTab[i]);
      rd(6'(cmd_dispatch_pkg::OFS_PROD_A + i));
      chk(rdVal, prodTab[i]);
    end
    d1 = 8'($urandom);
    d2 = 8'($urandom) | 8'hc0;
    wr(cmd_dispatch_pkg::OFS_FIRST_DAC, d1);
    wr(cmd_dispatch_pkg::OFS_SECOND_DAC, d2);
    rd(cmd_dispatch_pkg::OFS_FIRST_DAC);
    chk(rdVal, d1 & 8'h3f);
    rd(cmd_dispatch_pkg::OFS_SECOND_DAC);
    chk(rdVal, d2 & 8'h3f);
    // four select patterns against both aux pins: both, aux 1 only, aux 2 only, neither routed
    for (i = 0; i < 4; i++)
    begin
      wr(cmd_dispatch_pkg::OFS_ANALOG_TEST, selTab[i]);
      // rewrite the first dac under each select so the monitor checks its level at the pin
      wr(cmd_dispatch_pkg::OFS_FIRST_DAC, d1);
      // a pin not selected for its dac stays low and disabled
      exp1 = {1'b0, selTab[i][7:4] == 4'h1, (selTab[i][7:4] == 4'h1) ? d1[5:0] : 6'h00};
      exp2 = {1'b0, selTab[i][3:0] == 4'h1, (selTab[i][3:0] == 4'h1) ? d2[5:0] : 6'h00};
      @(posedge clock);
      #1 chk({1'b0, auxPin1Enable, auxPin1Level}, exp1);
      chk({1'b0, auxPin2Enable, auxPin2Level}, exp2);
    end
    rd(cmd_dispatch_pkg::OFS_ADC_SAMPLE);
    chk(rdVal, adcExp);
    wr(cmd_dispatch_pkg::OFS_ADC_SAMPLE, 8'h00);
    rd(cmd_dispatch_pkg::OFS_ADC_SAMPLE);
    chk(rdVal, adcExp);
    rd(6'h20);
    chk(rdVal, 8'h00);
    // stream codes take preloaded bytes at once; idle stops them
    for (i = 1; i < 5; i++)
    begin
      push(i);
      wr(A_CMD, 8'(i));
      drained(i);
      chk({4'h0, activeOp}, 8'(i));
      wr(A_CMD, 8'h00);
      chk({4'h0, activeOp}, 8'h00);
    end
    push(3);
    wr(A_CMD, 8'h0c);
    repeat (6) @(posedge clock);
    chk(8'(gotQ.size()), 8'h00);
    for (k = 3; k > 1; k--)
    begin
      slow <= 1'($urandom);
      wr(A_FRM, 8'h80);
      waitRx(1'b1);
      drained(k);
      waitRx(1'b0);
      chk({4'h0, activeOp}, 8'h0c);
      if (k == 3)
        push(2);
    end
    wr(A_CMD, 8'h57);
    chk({4'h0, activeOp}, 8'h0c);
    slow <= 1'b1;
    wr(A_FRM, 8'h80);
    waitRx(1'b1);
    wr(A_CMD, 8'h00);
    chk({activeOp, 3'h0, rxActive}, 8'h00);
    // argument operation: waits for its full count, then takes no more
    push(11);
    wr(A_CMD, 8'h0e);
    drained(11);
    chk({4'h0, activeOp}, 8'h0e);
    push(1);
    drained(1);
    push(2);
    drained(0);
    rd(cmd_dispatch_pkg::OFS_FIFO_LEVEL);
    chk(rdVal & 8'h7f, 8'h02);
    wr(A_CMD, 8'h08);
    chk({4'h0, activeOp}, 8'h08);
    waitRx(1'b1);
    waitRx(1'b0);
    chk({4'h0, activeOp}, 8'h00);
    push(3);
    wr(A_CMD, 8'h04);
    drained(5);
    // soft reset code abandons the stream and settles to idle
    wr(A_CMD, 8'h0f);
    @(posedge clock);
    #1 chk({4'h0, activeOp}, 8'h00);
    wr(A_CMD, 8'h00);
    test_done();
  end
endmodule : tb_top
bind command_dispatch cmd_dispatch_monitor mon_u (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .adcInPhase(adcInPhase),
  .adcQuadrature(adcQuadrature), .txDone(txDone), .rxDone(rxDone), .streamByte(streamByte),
  .streamValid(streamValid), .txActive(txActive), .rxActive(rxActive), .activeOp(activeOp),
  .auxPin1Level(auxPin1Level), .auxPin1Enable(auxPin1Enable), .auxPin2Level(auxPin2Level),
  .auxPin2Enable(auxPin2Enable));
